// File: rtl/fwp_flash_protect_erase.sv
// command logic for write-enable latch, whole-array erase and protection decode
`timescale 1ns/1ps

// Function
// - opcodes 60h and C7h both mean whole-array erase, identically.
// - erase runs only when the write-enable latch is 1 at release.
// - erase takes no address, ignores trailing bytes, starts at select release.
// - erase release off a byte boundary skips erase and clears the latch.
// - erase with any region protected does nothing and clears the latch.
// - busy is reported while an accepted erase runs; host polls it.
// - latch is cleared before the erase cycle finishes.
// - erase is self-timed, no longer than the whole-array erase time.
// - write-enable opcode sets the latch at release, trailing bytes ignored.
// - write-disable opcode clears the latch at release, trailing bytes ignored.
// - incomplete or misaligned enable/disable leaves the latch unchanged.
// - with latch 0, erase and protection writes are not executed.
// - six stored protection bits, changed only by the protection write.
// - coarse codes protect none, 1/16 to 1/2 top or bottom, or all.
// - fine codes protect none, 1/256 to 1/32 at top or bottom, or all.
// - complement bit inverts the selected region exactly.
// - write-protect pin never alters the region, only the update lock.
// - write-protect pin low rejects every protection bit change.
// - erased bytes read back as all ones.
module fwp_flash_protect_erase #(
    parameter int unsigned ERASE_CYCLES = fwp_pkg::WHOLE_ARRAY_ERASE_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // serial command link
    input wire logic chipSelectN,
    input wire logic serialClock,
    input wire logic serialDataIn,
    // write-protect pin
    input wire logic writeProtectN,
    // decoded status-register write of the protection bits
    input wire logic protectWriteStrobe,
    input wire logic [5:0] protectWriteData,
    // status
    output logic writeEnableLatch,
    output logic busy,
    output logic eraseDone,
    output logic protectLocked,
    // protection state
    output logic [5:0] protectBits,
    output logic protectEmpty,
    output logic [19:0] protectLow,
    output logic [19:0] protectHigh,
    // array side
    output logic arrayEraseActive,
    output logic [7:0] eraseFillByte
);

    logic rstSync1;
    logic rstSyncN;

    // reset released through two flops
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rstSync1 <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSyncN <= rstSync1;
        end
    end

    // serial receive state
    logic selectPrev;
    logic clockPrev;
    logic [7:0] shiftReg;
    logic [2:0] bitCount;
    logic opcodeDone;
    logic [7:0] opcode;
    logic next_selectPrev;
    logic next_clockPrev;
    logic [7:0] next_shiftReg;
    logic [2:0] next_bitCount;
    logic next_opcodeDone;
    logic [7:0] next_opcode;
    logic selectRelease;
    logic clockRise;

    always_comb begin
        next_selectPrev = chipSelectN;
        next_clockPrev = serialClock;
        next_shiftReg = shiftReg;
        next_bitCount = bitCount;
        next_opcodeDone = opcodeDone;
        next_opcode = opcode;
        selectRelease = chipSelectN && !selectPrev;
        clockRise = serialClock && !clockPrev && !chipSelectN;
        if (chipSelectN) begin
            // frame state cleared between frames; release uses the old values
            next_bitCount = fwp_pkg::BIT_COUNT_ZERO;
            next_opcodeDone = 1'b0;
            next_shiftReg = 8'h00;
        end else if (clockRise) begin
            next_shiftReg = {shiftReg[6:0], serialDataIn};
            next_bitCount = 3'(bitCount + 3'h1);
            // only the first byte is kept; later bytes are ignored
            if (bitCount == fwp_pkg::BIT_COUNT_LAST && !opcodeDone) begin
                next_opcode = {shiftReg[6:0], serialDataIn};
                next_opcodeDone = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            selectPrev <= 1'b1;
            clockPrev <= 1'b0;
            shiftReg <= 8'h00;
            bitCount <= 3'h0;
            opcodeDone <= 1'b0;
            opcode <= 8'h00;
        end else begin
            selectPrev <= next_selectPrev;
            clockPrev <= next_clockPrev;
            shiftReg <= next_shiftReg;
            bitCount <= next_bitCount;
            opcodeDone <= next_opcodeDone;
            opcode <= next_opcode;
        end
    end

    // protection region decode
    logic [5:0] protectStore;
    logic [2:0] sizeCode;
    logic [1:0] shiftAmount;
    logic [19:0] regionSize;
    logic baseNone;
    logic baseAll;
    logic decEmpty;
    logic [19:0] decLow;
    logic [19:0] decHigh;

    always_comb begin
        sizeCode = protectStore[fwp_pkg::PB_SIZE_HI:fwp_pkg::PB_SIZE_LO];
        shiftAmount = 2'(sizeCode - 3'h1);
        regionSize = fwp_pkg::REGION_COARSE;
        baseNone = (sizeCode == fwp_pkg::SIZE_NONE);
        baseAll = 1'b0;
        if (!protectStore[fwp_pkg::PB_GRANULARITY]) begin
            // 1/16 .. 1/2 of the array, or all above
            regionSize = fwp_pkg::REGION_COARSE << shiftAmount;
            baseAll = (sizeCode > fwp_pkg::SIZE_COARSE_MAX);
        end else if (sizeCode <= fwp_pkg::SIZE_FINE_MAX) begin
            regionSize = fwp_pkg::REGION_FINE << shiftAmount;
        end else if (sizeCode <= fwp_pkg::SIZE_FINE_HALF) begin
            regionSize = fwp_pkg::REGION_FINE << fwp_pkg::FINE_HALF_SHIFT;
        end else begin
            baseAll = 1'b1;
        end
        decEmpty = 1'b0;
        decLow = fwp_pkg::ARRAY_FIRST;
        decHigh = fwp_pkg::ARRAY_LAST;
        if (!protectStore[fwp_pkg::PB_COMPLEMENT]) begin
            if (baseNone) begin
                decEmpty = 1'b1;
            end else if (!baseAll) begin
                if (!protectStore[fwp_pkg::PB_TOP_BOTTOM]) begin
                    decLow = 20'(fwp_pkg::ARRAY_LAST - regionSize + fwp_pkg::ONE_ADDR);
                end else begin
                    decHigh = 20'(regionSize - fwp_pkg::ONE_ADDR);
                end
            end
        end else begin
            // exact complement of the plain region
            if (baseAll) begin
                decEmpty = 1'b1;
            end else if (!baseNone) begin
                if (!protectStore[fwp_pkg::PB_TOP_BOTTOM]) begin
                    decHigh = 20'(fwp_pkg::ARRAY_LAST - regionSize);
                end else begin
                    decLow = regionSize;
                end
            end
        end
    end

    // command execution
    fwp_pkg::fwp_state_type state;
    fwp_pkg::fwp_state_type next_state;
    logic [31:0] eraseCount;
    logic [31:0] next_eraseCount;
    logic welLatch;
    logic next_welLatch;
    logic [5:0] next_protectStore;
    logic next_eraseDone;
    logic isEraseOp;
    logic aligned;

    always_comb begin
        next_state = state;
        next_eraseCount = eraseCount;
        next_welLatch = welLatch;
        next_protectStore = protectStore;
        next_eraseDone = 1'b0;
        isEraseOp = (opcode == fwp_pkg::OP_ERASE_ALL_A)
            || (opcode == fwp_pkg::OP_ERASE_ALL_B);
        aligned = opcodeDone && (bitCount == fwp_pkg::BIT_COUNT_ZERO);
        unique case (state)
            fwp_pkg::FWP_IDLE: begin
                // commands act only at select release
                if (selectRelease && opcodeDone) begin
                    if (isEraseOp) begin
                        if (!aligned) begin
                            next_welLatch = 1'b0;
                        end else if (!decEmpty) begin
                            // protected array refuses the erase
                            next_welLatch = 1'b0;
                        end else if (welLatch) begin
                            next_state = fwp_pkg::FWP_ERASING;
                            next_eraseCount = ERASE_CYCLES;
                            // cleared at the start, well before the end
                            next_welLatch = 1'b0;
                        end
                    end else if (aligned && opcode == fwp_pkg::OP_WRITE_ENABLE) begin
                        next_welLatch = 1'b1;
                    end else if (aligned && opcode == fwp_pkg::OP_WRITE_DISABLE) begin
                        next_welLatch = 1'b0;
                    end
                end else if (protectWriteStrobe && welLatch && writeProtectN) begin
                    // the pin only locks updates
                    next_protectStore = protectWriteData;
                    next_welLatch = 1'b0;
                end
            end
            fwp_pkg::FWP_ERASING: begin
                // self-timed; ends exactly after the erase time
                if (eraseCount <= 32'h00000001) begin
                    next_state = fwp_pkg::FWP_IDLE;
                    next_eraseCount = 32'h00000000;
                    next_eraseDone = 1'b1;
                end else begin
                    next_eraseCount = 32'(eraseCount - 32'h00000001);
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            state <= fwp_pkg::FWP_IDLE;
            eraseCount <= 32'h00000000;
            welLatch <= 1'b0;
            protectStore <= fwp_pkg::PROTECT_RESET;
        end else begin
            state <= next_state;
            eraseCount <= next_eraseCount;
            welLatch <= next_welLatch;
            protectStore <= next_protectStore;
        end
    end

    // next values of the output flops
    logic next_busy;
    logic next_protectLocked;
    logic [5:0] next_protectBits;
    logic next_protectEmpty;
    logic [19:0] next_protectLow;
    logic [19:0] next_protectHigh;
    logic next_arrayEraseActive;
    logic [7:0] next_eraseFillByte;

    always_comb begin
        // busy follows the state edge, so it never lags the erase start
        next_busy = (next_state == fwp_pkg::FWP_ERASING);
        next_protectLocked = !writeProtectN;
        next_protectBits = protectStore;
        next_protectEmpty = decEmpty;
        next_protectLow = decLow;
        next_protectHigh = decHigh;
        next_arrayEraseActive = (next_state == fwp_pkg::FWP_ERASING);
        next_eraseFillByte = fwp_pkg::ERASED_BYTE;
    end

    // output registers; latch, busy, done and array flags match the state, protection outputs lag it by one cycle
    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            writeEnableLatch <= 1'b0;
            busy <= 1'b0;
            eraseDone <= 1'b0;
            protectLocked <= 1'b0;
            protectBits <= fwp_pkg::PROTECT_RESET;
            protectEmpty <= 1'b1;
            protectLow <= fwp_pkg::ARRAY_FIRST;
            protectHigh <= fwp_pkg::ARRAY_LAST;
            arrayEraseActive <= 1'b0;
            eraseFillByte <= fwp_pkg::ERASED_BYTE;
        end else begin
            writeEnableLatch <= next_welLatch;
            busy <= next_busy;
            eraseDone <= next_eraseDone;
            protectLocked <= next_protectLocked;
            protectBits <= next_protectBits;
            protectEmpty <= next_protectEmpty;
            protectLow <= next_protectLow;
            protectHigh <= next_protectHigh;
            arrayEraseActive <= next_arrayEraseActive;
            eraseFillByte <= next_eraseFillByte;
        end
    end

endmodule

// File: shared/fwp_pkg.sv
// constants and types for the flash write-protect and whole-array erase logic
package fwp_pkg;

    // command opcodes
    localparam logic [7:0] OP_ERASE_ALL_A = 8'h60;
    localparam logic [7:0] OP_ERASE_ALL_B = 8'hC7;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;

    // serial framing
    localparam int BYTE_BITS = 8;
    localparam logic [2:0] BIT_COUNT_LAST = 3'h7;
    localparam logic [2:0] BIT_COUNT_ZERO = 3'h0;

    // clock and erase timing
    localparam int CLOCK_HZ = 20000000;
    localparam int CYCLES_PER_MS = CLOCK_HZ / 1000;
    // whole_array_erase_time in ms, a plain default
    localparam int WHOLE_ARRAY_ERASE_TIME_MS = 4000;
    localparam int WHOLE_ARRAY_ERASE_CYCLES = WHOLE_ARRAY_ERASE_TIME_MS * CYCLES_PER_MS;

    // array geometry
    localparam int ADDR_W = 20;
    localparam logic [19:0] ARRAY_FIRST = 20'h00000;
    localparam logic [19:0] ARRAY_LAST = 20'hFFFFF;
    localparam logic [19:0] REGION_COARSE = 20'h10000;
    localparam logic [19:0] REGION_FINE = 20'h01000;
    localparam logic [19:0] ONE_ADDR = 20'h00001;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // protection bit layout
    localparam int PB_COMPLEMENT = 5;
    localparam int PB_GRANULARITY = 4;
    localparam int PB_TOP_BOTTOM = 3;
    localparam int PB_SIZE_HI = 2;
    localparam int PB_SIZE_LO = 0;
    localparam logic [5:0] PROTECT_RESET = 6'h00;

    // size codes
    localparam logic [2:0] SIZE_NONE = 3'h0;
    localparam logic [2:0] SIZE_COARSE_MAX = 3'h4;
    localparam logic [2:0] SIZE_FINE_MAX = 3'h3;
    localparam logic [2:0] SIZE_FINE_HALF = 3'h5;
    localparam logic [1:0] FINE_HALF_SHIFT = 2'h3;

    typedef enum logic {
        FWP_IDLE,
        FWP_ERASING
    } fwp_state_type;

endpackage

// File: verification/fwp_spi_host.sv
// serial command host model for the flash command link
`timescale 1ns/1ps
module fwp_spi_host (
    // clock
    input wire logic clock,
    // serial command link
    output logic chipSelectN,
    output logic serialClock,
    output logic serialDataIn
);
    initial begin
        chipSelectN = 1'h1;
        serialClock = 1'h0;
        serialDataIn = 1'h0;
    end
    // n bits msb first from w, then release; clock idles low between frames
    task automatic send(input logic [31:0] w, input int n);
        int i;
        @(posedge clock) #1 chipSelectN = 1'h0;
        for (i = 0; i < n; i++) begin
            serialDataIn = w[31 - i];
            repeat (2) @(posedge clock);
            #1 serialClock = 1'h1;
            repeat (2) @(posedge clock);
            #1 serialClock = 1'h0;
        end
        @(posedge clock) #1 chipSelectN = 1'h1;
        // released data line must not keep the last bit
        serialDataIn = ~serialDataIn;
        repeat (3) @(posedge clock);
    endtask
endmodule

// File: verification/fwp_flash_protect_erase_assertions.sv
// port checks for the command and protection logic
`timescale 1ns/1ps
module fwp_flash_protect_erase_assertions #(
    parameter int unsigned ERASE_CYCLES = 20
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // inputs
    input wire logic writeProtectN,
    input wire logic protectWriteStrobe,
    // outputs
    input wire logic writeEnableLatch,
    input wire logic busy,
    input wire logic eraseDone,
    input wire logic protectLocked,
    input wire logic [5:0] protectBits,
    input wire logic protectEmpty,
    input wire logic arrayEraseActive
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_erase_gate: assert property (
        $rose(busy) |-> $past(writeEnableLatch) && $past(protectEmpty)) else $error("bad erase");
    a_latch_clear: assert property ($rose(busy) |-> !writeEnableLatch)
        else $error("latch kept at erase");
    a_busy_min: assert property ($rose(busy) |-> busy[*8])
        else $error("busy too short");
    a_busy_max: assert property ($rose(busy) |-> ##[1:40] !busy)
        else $error("erase too long");
    a_done_pulse: assert property ($fell(busy) |-> eraseDone ##1 !eraseDone)
        else $error("done pulse wrong");
    a_array_active: assert property (arrayEraseActive == busy)
        else $error("array erase not busy");
    a_lock_follow: assert property (protectLocked == !$past(writeProtectN))
        else $error("lock not following pin");
    a_write_refused: assert property (
        protectWriteStrobe && (!writeProtectN || !writeEnableLatch)
        |-> ##2 protectBits == $past(protectBits)) else $error("refused write took");
endmodule

// File: verification/tb_fwp_flash_protect_erase.sv
// testbench for the command and protection logic
`timescale 1ns/1ps
module tb_fwp_flash_protect_erase;
    localparam int unsigned ERASE_CYCLES = 20;
    logic clock, rstn, chipSelectN, serialClock, serialDataIn, writeProtectN;
    logic protectWriteStrobe, writeEnableLatch, busy, protectLocked, protectEmpty;
    logic eraseDone, arrayEraseActive;
    logic [5:0] protectWriteData, protectBits, d;
    logic [19:0] protectLow, protectHigh;
    logic [7:0] eraseFillByte;
    logic [40:0] e;
    int fail_count, total_checks, cycles, seed, i;
    fwp_spi_host u_host (.clock(clock), .chipSelectN(chipSelectN),
        .serialClock(serialClock), .serialDataIn(serialDataIn));
    fwp_flash_protect_erase #(.ERASE_CYCLES(ERASE_CYCLES)) u_dut (.clock(clock), .rstn(rstn),
        .chipSelectN(chipSelectN), .serialClock(serialClock), .serialDataIn(serialDataIn),
        .writeProtectN(writeProtectN), .protectWriteStrobe(protectWriteStrobe),
        .protectWriteData(protectWriteData), .writeEnableLatch(writeEnableLatch), .busy(busy),
        .eraseDone(eraseDone), .protectLocked(protectLocked), .protectBits(protectBits),
        .protectEmpty(protectEmpty), .protectLow(protectLow), .protectHigh(protectHigh),
        .arrayEraseActive(arrayEraseActive), .eraseFillByte(eraseFillByte));
    always #25 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 25000) begin
            fail_count++;
            $display("[ERR] %0t timeout", $time);
            complete_run();
        end
    end
    task automatic check_flag(input logic g, input logic x);
        total_checks++;
        if (g !== x) begin
            fail_count++;
            $display("[ERR] %0t flag got %b exp %b", $time, g, x);
        end
    endtask
    task automatic check_word(input logic [19:0] g, input logic [19:0] x);
        total_checks++;
        if (g !== x) begin
            fail_count++;
            $display("[ERR] %0t word got %h exp %h", $time, g, x);
        end
    endtask
    task automatic prot_write(input logic [5:0] v, input logic wp);
        @(posedge clock) #1 protectWriteStrobe = 1'h1;
        protectWriteData = v;
        writeProtectN = wp;
        @(posedge clock) #1 protectWriteStrobe = 1'h0;
        repeat (3) @(posedge clock);
        check_flag(protectLocked, !wp);
        #1 writeProtectN = 1'h1;
    endtask
    // expected region as {empty, low, high}
    function automatic logic [40:0] region(input logic [5:0] b);
        logic [19:0] len, lo, hi;
        logic all;
        all = b[4] ? b[2:0] > 3'h5 : b[2:0] > 3'h4;
        len = b[4] ? (b[2] ? 20'h08000 : 20'h01000 << (b[2:0] - 3'h1))
                   : 20'h10000 << (b[2:0] - 3'h1);
        lo = b[3] ? 20'h00000 : 20'hFFFFF - len + 20'h00001;
        hi = b[3] ? len - 20'h00001 : 20'hFFFFF;
        if (all) {lo, hi} = {20'h00000, 20'hFFFFF};
        if (!b[5]) return {b[2:0] == 3'h0, lo, hi};
        if (b[2:0] == 3'h0) return {1'h0, 20'h00000, 20'hFFFFF};
        if (all) return {1'h1, lo, hi};
        if (lo == 20'h00000) return {1'h0, hi + 20'h00001, 20'hFFFFF};
        return {1'h0, 20'h00000, lo - 20'h00001};
    endfunction
    task automatic complete_run();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        clock = 1'h0;
        rstn = 1'h0;
        writeProtectN = 1'h1;
        protectWriteStrobe = 1'h0;
        protectWriteData = 6'h00;
        seed = 84281;
        repeat (5) @(posedge clock);
        #1 rstn = 1'h1;
        repeat (4) @(posedge clock);
        check_flag(protectEmpty, 1'h1);
        u_host.send({fwp_pkg::OP_WRITE_ENABLE, 24'h000000}, 5);
        check_flag(writeEnableLatch, 1'h0);
        u_host.send({fwp_pkg::OP_WRITE_ENABLE, 24'h000000}, 9);
        check_flag(writeEnableLatch, 1'h0);
        u_host.send({fwp_pkg::OP_ERASE_ALL_A, 24'h000000}, 8);
        check_flag(busy, 1'h0);
        u_host.send({fwp_pkg::OP_WRITE_ENABLE, 24'($random(seed))}, 16);
        check_flag(writeEnableLatch, 1'h1);
        u_host.send({fwp_pkg::OP_WRITE_DISABLE, 24'($random(seed))}, 12);
        check_flag(writeEnableLatch, 1'h1);
        u_host.send({fwp_pkg::OP_WRITE_DISABLE, 24'($random(seed))}, 24);
        check_flag(writeEnableLatch, 1'h0);
        d = 6'($random(seed));
        for (i = 0; i < 64; i++) begin
            d = d + 6'h01;
            e = region(d);
            u_host.send({fwp_pkg::OP_WRITE_ENABLE, 24'h000000}, 8);
            prot_write(~d, 1'h0);
            check_flag(writeEnableLatch, 1'h1);
            prot_write(d, 1'h1);
            prot_write(~d, 1'h1);
            check_word({14'h0000, protectBits}, {14'h0000, d});
            check_flag(protectEmpty, e[40]);
            if (!e[40]) begin
                check_word(protectLow, e[39:20]);
                check_word(protectHigh, e[19:0]);
                u_host.send({fwp_pkg::OP_WRITE_ENABLE, 24'h000000}, 8);
                u_host.send({fwp_pkg::OP_ERASE_ALL_B, 24'h000000}, 8);
                check_flag(busy, 1'h0);
                check_flag(writeEnableLatch, 1'h0);
            end
        end
        u_host.send({fwp_pkg::OP_WRITE_ENABLE, 24'h000000}, 8);
        prot_write(6'h00, 1'h1);
        for (i = 0; i < 2; i++) begin
            u_host.send({fwp_pkg::OP_WRITE_ENABLE, 24'h000000}, 8);
            u_host.send({i ? fwp_pkg::OP_ERASE_ALL_B : fwp_pkg::OP_ERASE_ALL_A,
                24'($random(seed))}, 8 * (1 + ($random(seed) & 3)));
            check_flag(busy, 1'h1);
            check_flag(arrayEraseActive, 1'h1);
            check_flag(writeEnableLatch, 1'h0);
            check_word({12'h000, eraseFillByte}, {12'h000, fwp_pkg::ERASED_BYTE});
            // busy rose two edges before send returned; it lasts the erase count
            repeat (ERASE_CYCLES - 3) @(posedge clock);
            #1 check_flag(busy, 1'h1);
            check_flag(eraseDone, 1'h0);
            @(posedge clock) #1 check_flag(busy, 1'h0);
            check_flag(eraseDone, 1'h1);
            check_flag(arrayEraseActive, 1'h0);
            @(posedge clock) #1 check_flag(eraseDone, 1'h0);
        end
        u_host.send({fwp_pkg::OP_WRITE_ENABLE, 24'h000000}, 8);
        u_host.send({fwp_pkg::OP_ERASE_ALL_A, 24'h000000}, 12);
        check_flag(busy, 1'h0);
        check_flag(writeEnableLatch, 1'h0);
        complete_run();
    end
endmodule
bind fwp_flash_protect_erase fwp_flash_protect_erase_assertions #(.ERASE_CYCLES(ERASE_CYCLES))
    u_chk (.clock(clock), .rstn(rstn), .writeProtectN(writeProtectN),
    .protectWriteStrobe(protectWriteStrobe), .writeEnableLatch(writeEnableLatch),
    .busy(busy), .eraseDone(eraseDone), .protectLocked(protectLocked),
    .protectBits(protectBits), .protectEmpty(protectEmpty),
    .arrayEraseActive(arrayEraseActive));
